// ---- hdl/eth_tx_descriptor_handler.sv ----
// transmit descriptor handler: fetch, buffer dispatch, status write-back
//
// Notes on behaviour
// - own bit 63 set means MAC owns
// - MAC clears own bit when done
// - zero first size skips first buffer
// - chained: second size ignored, next descriptor
// - end of ring returns to base
// - chained: second address is next descriptor
// - end of ring beats chained
// - start flag opens a new frame
// - end flag closes frame after buffer
// - select enable lets descriptor crc override
// - MAC writes back status bits 31:0 only when closing a descriptor with the end flag
// - excessive deferral abort sets status bit 12
// - word 1 holds two 32-bit addresses
// - host-owned descriptor flags unavailable, suspends
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ns
module eth_tx_descriptor_handler (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic [31:0] O_HRDATA,
  output logic O_HRESP,
  output logic O_MEM_VALID,
  output eth_txd_pkg::mem_req_t O_MEM,
  input wire logic I_MEM_ACK,
  input wire logic [63:0] I_MEM_RDATA,
  output logic O_BUF_VALID,
  output eth_txd_pkg::buf_cmd_t O_BUF,
  input wire logic I_BUF_DONE,
  input wire logic I_TX_DONE,
  input wire eth_txd_pkg::tx_result_t I_TX,
  output logic O_IRQ
);
  typedef struct packed {
    eth_txd_pkg::state_t st;
    eth_txd_pkg::desc_w0_t w0;
    logic [31:0] w1b;
    logic [31:0] cur;
    logic [31:0] base;
    logic run;
    logic dse;
    logic gcrc;
    logic poll;
    logic [2:0] mask;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic mem_valid;
    eth_txd_pkg::mem_req_t mem;
    logic buf_valid;
    eth_txd_pkg::buf_cmd_t bcmd;
    eth_txd_pkg::tx_result_t res;
    logic done_ev;
    logic nobuf_ev;
    logic exdef_ev;
    logic irq;
  } hdl_st_t;

  hdl_st_t r;
  hdl_st_t n;
  logic use1;
  logic use2;
  logic crc_sel;
  logic [31:0] next_ptr;
  logic [2:0] stat;
  logic [2:0] stat_set;
  logic [2:0] stat_clr;
  logic [31:0] rd_val;

  assign use1 = (r.w0.size1 != 11'h000);
  assign use2 = (r.w0.ering || !r.w0.chain) && (r.w0.size2 != 11'h000);
  assign crc_sel = r.dse ? r.w0.crc : r.gcrc;

  // address of the following fetch, loaded into cur when the close write-back is acked
  eth_txd_next_ptr u_next (
    .i_cur(r.cur),
    .i_base(r.base),
    .i_addr2(r.w1b),
    .i_ering(r.w0.ering),
    .i_chain(r.w0.chain),
    .o_next(next_ptr)
  );

  assign stat_set = {r.exdef_ev, r.nobuf_ev, r.done_ev};
  assign stat_clr = (r.wr_pend && r.wr_addr == eth_txd_pkg::REG_STAT) ? I_HWDATA[2:0] : 3'h0;

  for (genvar g = 0; g < eth_txd_pkg::IRQ_W; g++)
  begin : g_stat
    eth_txd_sticky u_bit (
      .i_clk(I_CLK),
      .i_resetn(I_RESETN),
      .i_set(stat_set[g]),
      .i_clr(stat_clr[g]),
      .o_q(stat[g])
    );
  end

  always_comb
  begin
    case (I_HADDR[7:0])
      eth_txd_pkg::REG_CTRL: rd_val = {29'h0000_0000, r.gcrc, r.dse, r.run};
      eth_txd_pkg::REG_STAT: rd_val = {29'h0000_0000, stat};
      eth_txd_pkg::REG_MASK: rd_val = {29'h0000_0000, r.mask};
      eth_txd_pkg::REG_BASE: rd_val = r.base;
      eth_txd_pkg::REG_CUR: rd_val = r.cur;
      eth_txd_pkg::REG_STATE: rd_val = {29'h0000_0000, r.st};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // word 0 as written back on close
  function automatic eth_txd_pkg::desc_w0_t close_word(
    input eth_txd_pkg::desc_w0_t w,
    input eth_txd_pkg::tx_result_t t,
    input logic fin
  );
    eth_txd_pkg::desc_w0_t o;
    o = w;
    o.own = 1'b0;
    if (fin)
    begin
      o.rsvd31 = 1'b0;
      o.len = t.len;
      o.rsvd19 = 5'h00;
      o.kind = t.kind;
      o.exdefer = t.exdefer;
      o.low = 12'h000;
    end
    return o;
  endfunction : close_word

  always_comb
  begin
    logic bufs_done;
    bufs_done = 1'b0;
    n = r;
    n.ready = 1'b1;
    n.resp = 1'b0;
    n.poll = 1'b0;
    n.wr_pend = 1'b0;
    n.done_ev = 1'b0;
    n.nobuf_ev = 1'b0;
    n.exdef_ev = 1'b0;
    n.irq = |(stat & r.mask);

    // bus data phase of a write
    if (r.wr_pend)
    begin
      case (r.wr_addr)
        eth_txd_pkg::REG_CTRL:
        begin
          n.run = I_HWDATA[eth_txd_pkg::CTRL_RUN];
          n.dse = I_HWDATA[eth_txd_pkg::CTRL_DSE];
          n.gcrc = I_HWDATA[eth_txd_pkg::CTRL_GCRC];
          n.poll = I_HWDATA[eth_txd_pkg::CTRL_POLL];
        end
        eth_txd_pkg::REG_MASK: n.mask = I_HWDATA[2:0];
        eth_txd_pkg::REG_BASE:
        begin
          n.base = I_HWDATA;
          n.cur = I_HWDATA;
        end
        default: n.mask = r.mask;
      endcase
    end

    // bus address phase
    if (I_HSEL && I_HREADY && I_HTRANS[1])
    begin
      n.wr_pend = I_HWRITE;
      n.wr_addr = I_HADDR[7:0];
      n.rdata = I_HWRITE ? 32'h0000_0000 : rd_val;
    end

    case (r.st)
      eth_txd_pkg::ST_IDLE:
      begin
        if (r.run)
        begin
          n.st = eth_txd_pkg::ST_FETCH0;
          n.mem_valid = 1'b1;
          n.mem = '{we: 1'b0, addr: r.cur, wdata: 64'h0};
        end
      end
      eth_txd_pkg::ST_FETCH0:
      begin
        if (I_MEM_ACK)
        begin
          n.w0 = I_MEM_RDATA;
          // host-owned: stop here, nothing of it is used
          if (!I_MEM_RDATA[eth_txd_pkg::OWN_POS])
          begin
            n.st = eth_txd_pkg::ST_SUSP;
            n.mem_valid = 1'b0;
            n.nobuf_ev = 1'b1;
          end
          else
          begin
            n.st = eth_txd_pkg::ST_FETCH1;
            n.mem.addr = r.cur + eth_txd_pkg::WORD1_OFS;
          end
        end
      end
      eth_txd_pkg::ST_FETCH1:
      begin
        if (I_MEM_ACK)
        begin
          n.w1b = I_MEM_RDATA[31:0];
          n.mem_valid = 1'b0;
          if (use1)
          begin
            n.st = eth_txd_pkg::ST_BUF1;
            n.buf_valid = 1'b1;
            n.bcmd = '{addr: I_MEM_RDATA[63:32], bytes: r.w0.size1, first: r.w0.sof,
                       last: r.w0.eof && !use2, crc: crc_sel};
          end
          else if (use2)
          begin
            n.st = eth_txd_pkg::ST_BUF2;
            n.buf_valid = 1'b1;
            n.bcmd = '{addr: I_MEM_RDATA[31:0], bytes: r.w0.size2, first: r.w0.sof,
                       last: r.w0.eof, crc: crc_sel};
          end
          else
          begin
            bufs_done = 1'b1;
          end
        end
      end
      eth_txd_pkg::ST_BUF1:
      begin
        if (I_BUF_DONE)
        begin
          n.buf_valid = 1'b0;
          if (use2)
          begin
            n.st = eth_txd_pkg::ST_BUF2;
            n.buf_valid = 1'b1;
            n.bcmd = '{addr: r.w1b, bytes: r.w0.size2, first: 1'b0, last: r.w0.eof, crc: crc_sel};
          end
          else
          begin
            bufs_done = 1'b1;
          end
        end
      end
      eth_txd_pkg::ST_BUF2:
      begin
        if (I_BUF_DONE)
        begin
          n.buf_valid = 1'b0;
          bufs_done = 1'b1;
        end
      end
      eth_txd_pkg::ST_WAITTX:
      begin
        if (I_TX_DONE)
        begin
          n.res = I_TX;
          n.st = eth_txd_pkg::ST_CLOSE;
          n.mem_valid = 1'b1;
          n.mem = '{we: 1'b1, addr: r.cur, wdata: close_word(r.w0, I_TX, 1'b1)};
        end
      end
      eth_txd_pkg::ST_CLOSE:
      begin
        if (I_MEM_ACK)
        begin
          n.mem_valid = 1'b0;
          n.mem.we = 1'b0;
          n.cur = next_ptr;
          n.done_ev = r.w0.eof;
          n.exdef_ev = r.w0.eof && r.res.exdefer;
          n.st = eth_txd_pkg::ST_IDLE;
        end
      end
      eth_txd_pkg::ST_SUSP:
      begin
        if (r.poll && r.run)
        begin
          n.st = eth_txd_pkg::ST_FETCH0;
          n.mem_valid = 1'b1;
          n.mem = '{we: 1'b0, addr: r.cur, wdata: 64'h0};
        end
      end
      default: n.st = eth_txd_pkg::ST_IDLE;
    endcase

    // buffers drained: wait for the frame if it ends here, else hand back
    if (bufs_done)
    begin
      if (r.w0.eof)
      begin
        n.st = eth_txd_pkg::ST_WAITTX;
      end
      else
      begin
        n.st = eth_txd_pkg::ST_CLOSE;
        n.mem_valid = 1'b1;
        n.mem = '{we: 1'b1, addr: r.cur, wdata: close_word(r.w0, r.res, 1'b0)};
      end
    end

    if (!I_RESETN)
    begin
      n = '0;
      n.st = eth_txd_pkg::ST_IDLE;
      n.ready = 1'b1;
      n.mask = eth_txd_pkg::MASK_RST;
      n.base = eth_txd_pkg::BASE_RST;
      n.cur = eth_txd_pkg::BASE_RST;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    r <= n;
  end

  assign O_HREADYOUT = r.ready;
  assign O_HRDATA = r.rdata;
  assign O_HRESP = r.resp;
  assign O_MEM_VALID = r.mem_valid;
  assign O_MEM = r.mem;
  assign O_BUF_VALID = r.buf_valid;
  assign O_BUF = r.bcmd;
  assign O_IRQ = r.irq;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);

  chk_own_gate:
    assert property ((r.st == eth_txd_pkg::ST_FETCH0 && I_MEM_ACK && !I_MEM_RDATA[63])
                     |=> (r.st == eth_txd_pkg::ST_SUSP && !r.mem_valid) ##1 !r.buf_valid)
      else $error("host-owned descriptor was processed");

  chk_nobuf_flag:
    assert property ((r.st == eth_txd_pkg::ST_FETCH0 && I_MEM_ACK && !I_MEM_RDATA[63])
                     |=> r.nobuf_ev ##1 stat[eth_txd_pkg::IRQ_NOBUF])
      else $error("buffer unavailable not flagged");

  chk_close_own:
    assert property ((r.st == eth_txd_pkg::ST_WAITTX && I_TX_DONE)
                     |=> (r.mem_valid && r.mem.we && !r.mem.wdata[63] && r.mem.addr == $past(r.cur)))
      else $error("close write does not clear ownership");

  chk_skip_first:
    assert property ((r.st == eth_txd_pkg::ST_FETCH1 && I_MEM_ACK && r.w0.size1 == 11'h000 && use2)
                     |=> (r.st == eth_txd_pkg::ST_BUF2 && r.bcmd.addr == $past(I_MEM_RDATA[31:0])))
      else $error("zero first size not skipped");

  chk_chain_nobuf2:
    assert property (r.st == eth_txd_pkg::ST_BUF2 |-> (r.w0.ering || !r.w0.chain))
      else $error("second buffer used while chained");

  chk_ring_wrap:
    assert property ((r.st == eth_txd_pkg::ST_CLOSE && I_MEM_ACK && r.w0.ering)
                     |=> r.cur == $past(r.base))
      else $error("end of ring did not return to base");

  chk_chain_next:
    assert property ((r.st == eth_txd_pkg::ST_CLOSE && I_MEM_ACK && r.w0.chain && !r.w0.ering)
                     |=> r.cur == $past(r.w1b))
      else $error("chained pointer not followed");

  chk_frame_marks:
    assert property (r.buf_valid |-> ((!r.bcmd.first || r.w0.sof) && (!r.bcmd.last || r.w0.eof)))
      else $error("frame marks disagree with descriptor");

  chk_crc_pick:
    assert property ((r.st == eth_txd_pkg::ST_FETCH1 && I_MEM_ACK && use1)
                     |=> r.bcmd.crc == $past(r.dse ? r.w0.crc : r.gcrc))
      else $error("crc append source wrong");

  chk_status_wb:
    assert property ((r.st == eth_txd_pkg::ST_WAITTX && I_TX_DONE)
                     |=> (r.mem.wdata[12] == $past(I_TX.exdefer) && r.mem.wdata[30:20] == $past(I_TX.len)))
      else $error("status write-back wrong");
endmodule : eth_tx_descriptor_handler

// ---- hdl/eth_txd_pkg.sv ----
// package: transmit descriptor layout, register map, states and carrier types
package eth_txd_pkg;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_BASE = 8'h0C;
  localparam logic [7:0] REG_CUR = 8'h10;
  localparam logic [7:0] REG_STATE = 8'h14;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_DSE = 1;
  localparam int CTRL_GCRC = 2;
  localparam int CTRL_POLL = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_NOBUF = 1;
  localparam int IRQ_EXDEF = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  localparam logic [31:0] WORD1_OFS = 32'h0000_0008;
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
  localparam int OWN_POS = 63;
  localparam int EXDEF_POS = 12;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FETCH0 = 3'h1,
    ST_FETCH1 = 3'h2,
    ST_BUF1 = 3'h3,
    ST_BUF2 = 3'h4,
    ST_WAITTX = 3'h5,
    ST_CLOSE = 3'h6,
    ST_SUSP = 3'h7
  } state_t;

  // descriptor word 0, bit 63 first
  typedef struct packed {
    logic own;
    logic [3:0] zero;
    logic [10:0] size1;
    logic [10:0] size2;
    logic ering;
    logic chain;
    logic sof;
    logic eof;
    logic crc;
    logic rsvd31;
    logic [10:0] len;
    logic [4:0] rsvd19;
    logic [1:0] kind;
    logic exdefer;
    logic [11:0] low;
  } desc_w0_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [10:0] bytes;
    logic first;
    logic last;
    logic crc;
  } buf_cmd_t;

  typedef struct packed {
    logic [10:0] len;
    logic [1:0] kind;
    logic exdefer;
  } tx_result_t;

  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [63:0] wdata;
  } mem_req_t;
endpackage : eth_txd_pkg

// ---- hdl/eth_txd_sticky.sv ----
// sticky status bit: set by an event, cleared by software, set wins
`timescale 1ns/1ns
module eth_txd_sticky (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_set,
  input wire logic i_clr,
  output logic o_q
);
  typedef struct packed {
    logic q;
  } sticky_st_t;

  sticky_st_t r;
  sticky_st_t n;

  always_comb
  begin
    n = r;
    n.q = i_set | (r.q & ~i_clr);
    if (!i_resetn)
    begin
      n.q = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    r <= n;
  end

  assign o_q = r.q;
endmodule : eth_txd_sticky

// ---- hdl/eth_txd_next_ptr.sv ----
// next descriptor address: ring wrap, chained pointer or sequential step
`timescale 1ns/1ns
module eth_txd_next_ptr (
  input wire logic [31:0] i_cur,
  input wire logic [31:0] i_base,
  input wire logic [31:0] i_addr2,
  input wire logic i_ering,
  input wire logic i_chain,
  output logic [31:0] o_next
);
  // end of ring wins over chaining
  assign o_next = i_ering ? i_base : (i_chain ? i_addr2 : i_cur + eth_txd_pkg::DESC_STRIDE);
endmodule : eth_txd_next_ptr

// ---- test/eth_txd_host_mem.sv ----
// host memory model: holds descriptors, answers fetch and close requests
`timescale 1ns/1ns
module eth_txd_host_mem (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_valid,
  input wire eth_txd_pkg::mem_req_t i_req,
  input wire logic [3:0] i_lat,
  output logic o_ack,
  output logic [63:0] o_rdata
);
  logic [63:0] mem [64];
  logic [3:0] cnt = 4'h0;
  initial
  begin
    o_ack = 1'b0;
    o_rdata = 64'h0;
    foreach (mem[i]) mem[i] = 64'h0;
  end
  // read data is meaningful only with a read ack; it toggles when idle or acked, holds while counting latency
  always @(posedge i_clk)
  begin
    if (!i_resetn || !i_valid || o_ack)
    begin
      o_ack <= 1'b0;
      cnt <= 4'h0;
      o_rdata <= ~o_rdata;
    end
    else if (cnt == i_lat)
    begin
      o_ack <= 1'b1;
      if (i_req.we)
        mem[i_req.addr[8:3]] <= i_req.wdata;
      else
        o_rdata <= mem[i_req.addr[8:3]];
    end
    else
      cnt <= cnt + 4'h1;
  end
endmodule : eth_txd_host_mem

// ---- test/eth_tx_descriptor_handler_test.sv ----
// testbench: descriptor handler against a host memory model
`timescale 1ns/1ns
module eth_tx_descriptor_handler_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp, mem_valid, mem_ack, buf_valid, irq;
  logic [31:0] hrdata;
  logic [63:0] mem_rdata;
  logic buf_done = 1'b0;
  logic tx_done = 1'b0;
  logic [3:0] lat = 4'h0;
  logic [1:0] bcnt = 2'h0;
  eth_txd_pkg::mem_req_t mem_req;
  eth_txd_pkg::buf_cmd_t buf_cmd;
  eth_txd_pkg::tx_result_t tx = '0;
  eth_txd_pkg::buf_cmd_t bq[$];
  int err_count = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  eth_tx_descriptor_handler dut (.I_CLK(clk), .I_RESETN(resetn), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HREADYOUT(hready), .O_HRDATA(hrdata), .O_HRESP(hresp), .O_MEM_VALID(mem_valid), .O_MEM(mem_req),
    .I_MEM_ACK(mem_ack), .I_MEM_RDATA(mem_rdata), .O_BUF_VALID(buf_valid), .O_BUF(buf_cmd),
    .I_BUF_DONE(buf_done), .I_TX_DONE(tx_done), .I_TX(tx), .O_IRQ(irq));
  eth_txd_host_mem host (.i_clk(clk), .i_resetn(resetn), .i_valid(mem_valid), .i_req(mem_req),
    .i_lat(lat), .o_ack(mem_ack), .o_rdata(mem_rdata));
  // buffer side: empties each buffer a few cycles after it is handed over
  always @(posedge clk)
  begin
    if (!buf_valid || buf_done)
    begin
      buf_done <= 1'b0;
      bcnt <= 2'h0;
    end
    else if (bcnt == 2'h2)
    begin
      buf_done <= 1'b1;
      bq.push_back(buf_cmd);
    end
    else
      bcnt <= bcnt + 2'h1;
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk({32'h0, r}, {32'h0, exp});
  endtask : rd_chk
  task wait_state(input logic [2:0] s);
    logic [31:0] r;
    r = 32'hFFFF_FFFF;
    for (int i = 0; i < 300 && r !== {29'h0, s}; i++) xfer(1'b0, eth_txd_pkg::REG_STATE, 32'h0, r);
    if (r !== {29'h0, s})
    begin
      err_count++;
      $display("mismatch at %0t: state %0d not reached", $time, s);
    end
  endtask : wait_state
  task get_buf(output eth_txd_pkg::buf_cmd_t c);
    for (int i = 0; i < 500 && bq.size() == 0; i++) @(posedge clk);
    c = '0;
    if (bq.size() == 0)
    begin
      err_count++;
      $display("mismatch at %0t: no buffer command", $time);
    end
    else
      c = bq.pop_front();
  endtask : get_buf
  task frame_end(input logic [10:0] len, input logic [1:0] kind, input logic exd);
    wait_state(3'h5);
    tx_done <= 1'b1;
    tx <= '{len: len, kind: kind, exdefer: exd};
    @(posedge clk);
    tx_done <= 1'b0;
  endtask : frame_end
  // owned word 0 with zero reserved bits; ctl is end-of-ring, chained, start, end, crc
  function logic [63:0] dw0(input logic [10:0] s1, input logic [10:0] s2, input logic [4:0] ctl);
    return {1'b1, 4'h0, s1, s2, ctl, 32'h0};
  endfunction : dw0
  task test_reset;
    rd_chk(eth_txd_pkg::REG_STATE, 32'h0);
    rd_chk(eth_txd_pkg::REG_STAT, 32'h0);
    rd_chk(8'h40, 32'h0);
    wr(eth_txd_pkg::REG_MASK, 32'h5);
    rd_chk(eth_txd_pkg::REG_MASK, 32'h5);
    wr(eth_txd_pkg::REG_MASK, 32'h0);
    $display("reset test done");
  endtask : test_reset
  task test_frame;
    eth_txd_pkg::buf_cmd_t c;
    logic [63:0] d;
    d = dw0(11'h5, 11'h7, 5'h07);
    host.mem[1] = {32'h1000, 32'h2000};
    host.mem[2] = 64'h0;
    host.mem[0] = d;
    wr(eth_txd_pkg::REG_BASE, 32'h0);
    wr(eth_txd_pkg::REG_CTRL, 32'h3);
    get_buf(c);
    chk(c, {32'h1000, 11'h5, 3'b101});
    get_buf(c);
    chk(c, {32'h2000, 11'h7, 3'b011});
    frame_end(11'h3C, 2'h1, 1'b1);
    wait_state(3'h7);
    chk(host.mem[0], {1'b0, d[62:32], 1'b0, 11'h3C, 5'h0, 2'h1, 1'b1, 12'h0});
    rd_chk(eth_txd_pkg::REG_STAT, 32'h7);
    rd_chk(eth_txd_pkg::REG_CUR, 32'h10);
    chk(irq, 1'b0);
    wr(eth_txd_pkg::REG_MASK, 32'h2);
    // irq registers one edge after the mask; look one edge later, on the edge
    @(posedge clk);
    @(posedge clk);
    chk(irq, 1'b1);
    wr(eth_txd_pkg::REG_STAT, 32'h2);
    @(posedge clk);
    @(posedge clk);
    chk(irq, 1'b0);
    rd_chk(eth_txd_pkg::REG_STAT, 32'h5);
    $display("frame test done");
  endtask : test_frame
  task test_ring;
    eth_txd_pkg::buf_cmd_t c;
    logic [7:0] a [3];
    logic [63:0] w [3];
    logic [63:0] w1 [3];
    logic [1:0] kd [3];
    eth_txd_pkg::buf_cmd_t e [3];
    a = '{8'h20, 8'h30, 8'h80};
    kd = '{2'h0, 2'h2, 2'h3};
    w = '{dw0(11'h0, 11'h4, 5'h06), dw0(11'h3, 11'h9, 5'h0E), dw0(11'h2, 11'h0, 5'h1E)};
    w1 = '{{32'h3000, 32'h4000}, {32'h5000, 32'h80}, {32'h6000, 32'h40}};
    e = '{{32'h4000, 11'h4, 3'b111}, {32'h5000, 11'h3, 3'b111}, {32'h6000, 11'h2, 3'b111}};
    lat <= 4'h3;
    for (int i = 0; i < 3; i++)
    begin
      host.mem[a[i][7:3] + 1] = w1[i];
      host.mem[a[i][7:3]] = w[i];
    end
    wr(eth_txd_pkg::REG_BASE, 32'h20);
    wr(eth_txd_pkg::REG_CTRL, 32'hD);
    for (int i = 0; i < 3; i++)
    begin
      get_buf(c);
      chk(c, e[i]);
      frame_end(11'h40 + 11'(i), kd[i], 1'b0);
    end
    wait_state(3'h7);
    rd_chk(eth_txd_pkg::REG_CUR, 32'h20);
    for (int i = 0; i < 3; i++)
      chk(host.mem[a[i][7:3]], {1'b0, w[i][62:32], 1'b0, 11'h40 + 11'(i), 5'h0, kd[i], 13'h0});
    $display("ring test done");
  endtask : test_ring
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    test_reset;
    test_frame;
    test_ring;
    print_verdict;
  end
  initial
  begin
    #40000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict;
  end
endmodule : eth_tx_descriptor_handler_test
